// [core/uftr_pkg.sv]
// What this block does
// - frame is start, 5..9 data bits, optional even/odd parity, 1 or 2 stops
// - start bit low, stop bits high, line rests high when idle
// - even parity bit is one for odd ones count, odd parity the reverse
// - receiver recomputes parity and flags a mismatch
// - master spi frame is eight bits, no framing, msb or lsb first
// - next spi frame may follow at once or line returns high
// - enabled transmitter overrides the output pin and drives the stream
// - one-wire mode turns the shared pin to output when transmitter on
// - holding buffer loads shifter when idle or right after last stop
// - frame done with empty holding buffer sets transmit complete flag
// - unused upper transmit bits are ignored for short characters
// - transmitter disable waits until shifter and buffer are empty
// - disabled transmitter releases the pin as an input
// - reception starts on valid start, sampled up to the first stop
// - first stop moves frame into buffer and sets receive complete
// - unused upper received bits read as zero
// - error flags travel in the fifo; reading the low byte advances it
// - lin mode checks parity only on the protected identifier
// - lin identifier parity error if p0 or p1 equation fails
// - bit level is majority of samples 8..10 of 16 or 4..6 of 8
// - first stop sampled as zero sets the frame error flag
// - receiver disable is immediate, flushes buffer and current frame
package uftr_pkg;
  localparam int unsigned CHAR_W = 9;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned SPI_BITS = 8;
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [8:0] DATA_RST = 9'h000;

  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic spi_master;
    logic one_wire;
    logic double_speed;
    logic receiver_mode_field; // lin mode when set
    logic [1:0] parity_select;
    logic two_stop;
    logic [3:0] char_size; // 5..9 data bits
    logic bit_order_select; // spi: high means lsb first
  } uftr_cfg_t;

  typedef struct packed {
    logic frame_error;
    logic overflow;
    logic parity_error;
    logic [8:0] data;
  } uftr_rx_entry_t;

  localparam int unsigned ENTRY_W = $bits(uftr_rx_entry_t);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uftr_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} uftr_rx_state_t;
endpackage

// [core/uftr_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module uftr_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ready_q, ready_d, valid_q, valid_d, do_wr, do_rd;

  // pointers and fill level; flags are registered from the next count
  always_comb begin
    do_wr = in_valid && ready_q;
    do_rd = out_ready && valid_q;
    wr_d = do_wr ? wr_q + 1'b1 : wr_q;
    rd_d = do_rd ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + CW'(do_wr) - CW'(do_rd);
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    ready_d = cnt_d != FULL_CNT;
    valid_d = cnt_d != '0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  // storage has no reset; out_data shows mem_q[rd_q] even when no written entry is held
  always_ff @(posedge core_clk) begin
    if (do_wr && !flush) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[rd_q];
endmodule
`default_nettype wire

// [core/uftr_core.sv]
`timescale 1ns/100ps
`default_nettype none
module uftr_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire uftr_pkg::uftr_cfg_t cfg,
  input wire logic sample_tick, // one pulse per sample period from the baud divider
  input wire logic tx_write,
  input wire logic [8:0] transmit_holding,
  input wire logic tx_complete_clear,
  input wire logic rxd_pin,
  input wire logic lin_pid_frame,
  input wire logic receive_low_read,
  output logic txd_out,
  output logic txd_oe,
  output logic pin_override,
  output logic sck_out,
  output logic tx_buffer_empty_flag,
  output logic tx_complete_flag,
  output logic rx_complete_flag,
  output logic [8:0] receive_holding,
  output logic frame_error_flag,
  output logic overflow_flag,
  output logic parity_error_flag
);
  import uftr_pkg::*;

  // mask of the live character bits
  function automatic logic [8:0] char_mask(input logic [3:0] n);
    char_mask = 9'h1FF >> (4'h9 - n);
  endfunction

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [8:0] rev8(input logic [8:0] v);
    logic [8:0] r;
    r = DATA_RST;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    rev8 = r;
  endfunction

  logic [4:0] bit_len, vote_first;
  logic par_en;
  logic [3:0] nbits;

  // per-mode frame shape
  always_comb begin
    bit_len = cfg.double_speed ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    vote_first = cfg.double_speed ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    par_en = cfg.parity_select[1] && !cfg.spi_master && !cfg.receiver_mode_field;
    nbits = cfg.spi_master ? 4'(SPI_BITS) : cfg.char_size;
  end

  // ---------------- transmitter ----------------
  uftr_tx_state_t tx_st_q, tx_st_d;
  logic [4:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [8:0] tx_sh_q, tx_sh_d, hold_q, hold_d, load_val;
  logic tx_par_q, tx_par_d, hold_empty_q, hold_empty_d;
  logic txc_q, txc_d, tx_on_q, tx_on_d;
  logic txd_q, txd_d, sck_q, sck_d;
  logic tx_bit_end, frame_done, spi_sample, spi_last;

  // transmit sequencing, holding buffer and complete flag
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_par_d = tx_par_q;
    hold_d = hold_q;
    hold_empty_d = hold_empty_q;
    txc_d = txc_q;
    frame_done = 1'b0;
    spi_sample = 1'b0;
    spi_last = 1'b0;
    load_val = hold_q & char_mask(nbits);
    tx_bit_end = sample_tick && tx_cnt_q == bit_len - 5'h01;
    // writes while the buffer is full are dropped
    if (tx_write && hold_empty_q) begin
      hold_d = transmit_holding;
      hold_empty_d = 1'b0;
    end
    if (tx_complete_clear) begin
      txc_d = 1'b0;
    end
    if (tx_st_q != TX_IDLE && sample_tick) begin
      tx_cnt_d = tx_bit_end ? CNT_RST : tx_cnt_q + 5'h01;
    end
    // receiver of spi master captures at mid-bit, on the rising clock
    spi_sample = cfg.spi_master && tx_st_q == TX_DATA && sample_tick &&
                 tx_cnt_q == (bit_len >> 1) - 5'h01;
    unique case (tx_st_q)
      TX_IDLE: ;
      TX_START: if (tx_bit_end) begin
        tx_st_d = TX_DATA;
        tx_bit_d = BIT_RST;
      end
      TX_DATA: if (tx_bit_end) begin
        tx_sh_d = tx_sh_q >> 1;
        tx_bit_d = tx_bit_q + 4'h1;
        if (tx_bit_q == nbits - 4'h1) begin
          tx_bit_d = BIT_RST;
          if (cfg.spi_master) begin
            frame_done = 1'b1;
            spi_last = 1'b1;
            tx_st_d = TX_IDLE;
          end else begin
            tx_st_d = par_en ? TX_PARITY : TX_STOP;
          end
        end
      end
      TX_PARITY: if (tx_bit_end) begin
        tx_st_d = TX_STOP;
      end
      TX_STOP: if (tx_bit_end) begin
        if (cfg.two_stop && tx_bit_q == BIT_RST) begin
          tx_bit_d = 4'h1;
        end else begin
          frame_done = 1'b1;
          tx_st_d = TX_IDLE;
        end
      end
    endcase
    // load when idle or straight after the last stop, so frames run back to back
    if (tx_st_d == TX_IDLE && !hold_empty_q && tx_on_q) begin
      tx_st_d = cfg.spi_master ? TX_DATA : TX_START;
      tx_cnt_d = CNT_RST;
      tx_bit_d = BIT_RST;
      tx_sh_d = (cfg.spi_master && !cfg.bit_order_select) ? rev8(load_val) : load_val;
      // even: one when ones count is odd; odd: the inverse
      tx_par_d = (^load_val) ^ (cfg.parity_select == PAR_ODD);
      hold_empty_d = 1'b0;
      if (!(tx_write && hold_empty_q)) begin
        hold_empty_d = 1'b1;
      end
    end else if (frame_done) begin
      txc_d = 1'b1; // set wins over clear
    end
    // disable holds off until nothing is left to send
    tx_on_d = cfg.tx_enable || tx_st_d != TX_IDLE || !hold_empty_d;
    unique case (tx_st_d)
      TX_START: txd_d = 1'b0;
      TX_DATA: txd_d = tx_sh_d[0];
      TX_PARITY: txd_d = tx_par_d;
      default: txd_d = 1'b1;
    endcase
    sck_d = cfg.spi_master && tx_st_d == TX_DATA && tx_cnt_d >= (bit_len >> 1);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= CNT_RST;
      tx_bit_q <= BIT_RST;
      tx_sh_q <= DATA_RST;
      tx_par_q <= 1'b0;
      hold_q <= DATA_RST;
      hold_empty_q <= 1'b1;
      txc_q <= 1'b0;
      tx_on_q <= 1'b0;
      txd_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_par_q <= tx_par_d;
      hold_q <= hold_d;
      hold_empty_q <= hold_empty_d;
      txc_q <= txc_d;
      tx_on_q <= tx_on_d;
      txd_q <= txd_d;
      sck_q <= sck_d;
    end
  end

  // pin ownership: driven while on, input again once released;
  // in one-wire mode the same enable turns the shared pin around
  assign txd_out = txd_q;
  assign txd_oe = tx_on_q;
  assign pin_override = tx_on_q;
  assign sck_out = sck_q;
  assign tx_buffer_empty_flag = hold_empty_q;
  assign tx_complete_flag = txc_q;

  // ---------------- receiver ----------------
  logic rx_meta_q, rx_sync_q;

  // two-stage synchroniser, the first stage feeds nothing else
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  uftr_rx_state_t rx_st_q, rx_st_d;
  logic [4:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [8:0] rx_sh_q, rx_sh_d, rx_data;
  logic [2:0] vote_q, vote_d;
  logic rx_prev_q, rx_prev_d, rx_par_q, rx_par_d;
  logic push_q, push_d, ovf_pend_q, ovf_pend_d;
  uftr_rx_entry_t ent_q, ent_d, fifo_out;
  logic fifo_ready, fifo_valid, bit_val, calc_par, lin_bad;

  // sampling, majority vote, framing and overflow bookkeeping
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    vote_d = vote_q;
    rx_prev_d = rx_prev_q;
    rx_par_d = rx_par_q;
    push_d = 1'b0;
    ent_d = ent_q;
    ovf_pend_d = ovf_pend_q;
    bit_val = maj3(vote_q);
    rx_data = DATA_RST;
    calc_par = 1'b0;
    lin_bad = 1'b0;
    if (sample_tick) begin
      rx_prev_d = rx_sync_q;
    end
    // a frame offered to a full fifo is dropped; the next stored one carries the mark
    if (push_q) begin
      if (fifo_ready) begin
        ovf_pend_d = 1'b0;
      end else begin
        ovf_pend_d = 1'b1;
      end
    end
    if (cfg.spi_master) begin
      rx_st_d = RX_IDLE;
      if (spi_sample) begin
        rx_sh_d = cfg.bit_order_select ? {rx_sync_q, rx_sh_q[8:1]} : {rx_sh_q[7:0], rx_sync_q};
      end
      if (spi_last) begin
        push_d = 1'b1;
        ent_d.data = (cfg.bit_order_select ? rx_sh_q >> 1 : rx_sh_q) & 9'h0FF;
        ent_d.frame_error = 1'b0;
        ent_d.parity_error = 1'b0;
      end
    end else if (sample_tick) begin
      rx_cnt_d = (rx_cnt_q == bit_len) ? 5'h01 : rx_cnt_q + 5'h01;
      if (rx_cnt_q >= vote_first && rx_cnt_q <= vote_first + 5'h02) begin
        vote_d = {vote_q[1:0], rx_sync_q};
      end
      bit_val = maj3({vote_q[1:0], rx_sync_q});
      unique case (rx_st_q)
        RX_IDLE: if (rx_prev_q && !rx_sync_q) begin
          rx_st_d = RX_START;
          rx_cnt_d = 5'h02; // this sample is sample 1
          rx_bit_d = BIT_RST;
        end
        RX_START: if (rx_cnt_q == vote_first + 5'h02) begin
          // a high majority was only a spike
          rx_st_d = bit_val ? RX_IDLE : RX_BITS;
        end
        RX_BITS: if (rx_cnt_q == vote_first + 5'h02) begin
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q < nbits) begin
            rx_sh_d = {bit_val, rx_sh_q[8:1]};
          end else if (par_en && rx_bit_q == nbits) begin
            rx_par_d = bit_val;
          end else begin
            // first stop ends the frame; a second stop is never waited for
            rx_st_d = RX_IDLE;
            rx_data = (rx_sh_q >> (4'h9 - nbits)) & char_mask(nbits);
            calc_par = (^rx_data) ^ (cfg.parity_select == PAR_ODD);
            // p0 = id0^id1^id2^id4, p1 = ~(id1^id3^id4^id5)
            lin_bad = (rx_data[6] != (rx_data[0] ^ rx_data[1] ^ rx_data[2] ^ rx_data[4])) ||
                      (rx_data[7] != !(rx_data[1] ^ rx_data[3] ^ rx_data[4] ^ rx_data[5]));
            push_d = 1'b1;
            ent_d.data = rx_data;
            ent_d.frame_error = !bit_val;
            ent_d.parity_error = cfg.receiver_mode_field ? (lin_pid_frame && lin_bad)
                                 : (par_en && calc_par != rx_par_q);
          end
        end
        default: rx_st_d = RX_IDLE;
      endcase
    end
    ent_d.overflow = ovf_pend_d;
    // disabling drops the frame in flight right away
    if (!cfg.rx_enable) begin
      rx_st_d = RX_IDLE;
      push_d = 1'b0;
      ovf_pend_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= CNT_RST;
      rx_bit_q <= BIT_RST;
      rx_sh_q <= DATA_RST;
      vote_q <= 3'h7;
      rx_prev_q <= 1'b1;
      rx_par_q <= 1'b0;
      push_q <= 1'b0;
      ent_q <= '0;
      ovf_pend_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      vote_q <= vote_d;
      rx_prev_q <= rx_prev_d;
      rx_par_q <= rx_par_d;
      push_q <= push_d;
      ent_q <= ent_d;
      ovf_pend_q <= ovf_pend_d;
    end
  end

  // frames and their error flags queue together; low-byte read pops
  uftr_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(!cfg.rx_enable),
    .in_valid(push_q && cfg.rx_enable),
    .in_ready(fifo_ready),
    .in_data(ent_q),
    .out_valid(fifo_valid),
    .out_ready(receive_low_read),
    .out_data(fifo_out)
  );

  // head entry is held in storage flops until popped
  assign rx_complete_flag = fifo_valid;
  assign receive_holding = fifo_out.data;
  assign frame_error_flag = fifo_out.frame_error;
  assign overflow_flag = fifo_out.overflow;
  assign parity_error_flag = fifo_out.parity_error;
endmodule
`default_nettype wire

// [testbench/uftr_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module uftr_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire uftr_pkg::uftr_cfg_t cfg,
  input wire logic tx_write,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic tx_buffer_empty_flag,
  input wire logic tx_complete_flag,
  input wire logic rx_complete_flag,
  input wire logic [8:0] receive_holding
);
  import uftr_pkg::*;
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // transmit side: start, buffer hand-over, pin ownership
  property p_tx_start;
    tx_write && tx_buffer_empty_flag && tx_complete_flag && cfg.tx_enable && !cfg.spi_master
      |-> ##[1:3] !txd_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("frame start missing");
  property p_empty_drop;
    tx_write && tx_buffer_empty_flag |-> ##[1:2] !tx_buffer_empty_flag;
  endproperty
  a_empty_drop: assert property (p_empty_drop) else $error("write not taken");
  property p_idle_high;
    !txd_oe |-> txd_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high");
  property p_oe_on;
    cfg.tx_enable |=> txd_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  // release only once nothing is left to send
  property p_drain;
    $fell(txd_oe) |-> tx_buffer_empty_flag && txd_out;
  endproperty
  a_drain: assert property (p_drain) else $error("pin released early");
  property p_release;
    !cfg.tx_enable && tx_complete_flag && tx_buffer_empty_flag && !tx_write |=> !txd_oe;
  endproperty
  a_release: assert property (p_release) else $error("pin kept after disable");
  property p_tc_rise;
    $rose(tx_complete_flag) |-> tx_buffer_empty_flag && (txd_out || cfg.spi_master);
  endproperty
  a_tc_rise: assert property (p_tc_rise) else $error("complete while busy");
  // receive side: flush and zero padding
  property p_flush;
    !cfg.rx_enable [*2] |=> !rx_complete_flag;
  endproperty
  a_flush: assert property (p_flush) else $error("buffer not flushed");
  property p_short_char;
    rx_complete_flag && cfg.char_size == 4'h5 |-> receive_holding[8:5] == 4'h0;
  endproperty
  a_short_char: assert property (p_short_char) else $error("upper bits set");
endmodule
bind uftr_core uftr_monitor u_mon (.core_clk(core_clk), .rst(rst), .cfg(cfg),
  .tx_write(tx_write), .txd_out(txd_out), .txd_oe(txd_oe),
  .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_complete_flag(tx_complete_flag),
  .rx_complete_flag(rx_complete_flag), .receive_holding(receive_holding));
`default_nettype wire

// [testbench/uftr_remote.sv]
`timescale 1ns/100ps
`default_nettype none
module uftr_remote (
  input wire logic core_clk,
  input wire logic sample_tick,
  input wire uftr_pkg::uftr_cfg_t cfg,
  input wire logic txd,
  input wire logic sck,
  output logic rxd
);
  import uftr_pkg::*;
  logic [8:0] got_data = 9'h000;
  logic got_par = 1'b0;
  logic got_stop = 1'b0;
  logic [7:0] spi_q = 8'h00;
  int bl;
  // sample periods per bit follow the speed mode
  assign bl = cfg.double_speed ? 8 : 16;
  initial rxd = 1'b1;
  // whole sample periods of the shared divider
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk iff sample_tick);
  endtask
  // one frame; caller masks d to the character size
  task automatic send(input logic [8:0] d, input logic bad_par, input logic stop);
    rxd <= 1'b0;
    ticks(bl);
    for (int i = 0; i < int'(cfg.char_size); i++) begin
      rxd <= d[i];
      ticks(bl);
    end
    if (cfg.parity_select[1] && !cfg.receiver_mode_field) begin
      rxd <= ^d ^ cfg.parity_select[0] ^ bad_par;
      ticks(bl);
    end
    rxd <= stop;
    ticks(bl);
    rxd <= 1'b1; // idle high
    ticks(32);
  endtask
  // runt pulse, too short to win the vote
  task automatic glitch();
    rxd <= 1'b0;
    ticks(3);
    rxd <= 1'b1;
    ticks(40);
  endtask
  // mid-bit decode of async frames from the device
  always begin
    @(negedge txd);
    if (!cfg.spi_master) begin
      ticks(bl / 2);
      got_data = 9'h000;
      for (int i = 0; i < int'(cfg.char_size); i++) begin
        ticks(bl);
        got_data[i] = txd;
      end
      if (cfg.parity_select[1]) begin
        ticks(bl);
        got_par = txd;
      end
      ticks(bl);
      got_stop = txd;
    end
  end
  // spi slave shifts on the rising clock
  always @(posedge sck) spi_q <= {spi_q[6:0], txd};
endmodule
`default_nettype wire

// [testbench/usart_frame_tx_rx_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module usart_frame_tx_rx_bench;
  import uftr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_tick = 1'b0;
  logic tx_write = 1'b0;
  logic tx_complete_clear = 1'b0;
  logic lin_pid_frame = 1'b0;
  logic receive_low_read = 1'b0;
  logic [8:0] transmit_holding = 9'h000;
  uftr_cfg_t cfg = '0;
  logic rxd_pin, txd_out, txd_oe, pin_override, sck_out, tx_buffer_empty_flag;
  logic tx_complete_flag, rx_complete_flag, frame_error_flag, overflow_flag, parity_error_flag;
  logic [8:0] receive_holding;
  logic [8:0] w;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // a released pin floats up to its pull-up
  wire logic txd_line = txd_oe ? txd_out : 1'b1;
  uftr_core u_dut (.core_clk(core_clk), .rst(rst), .cfg(cfg), .sample_tick(sample_tick),
    .tx_write(tx_write), .transmit_holding(transmit_holding),
    .tx_complete_clear(tx_complete_clear), .rxd_pin(rxd_pin), .lin_pid_frame(lin_pid_frame),
    .receive_low_read(receive_low_read), .txd_out(txd_out), .txd_oe(txd_oe),
    .pin_override(pin_override), .sck_out(sck_out),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_complete_flag(tx_complete_flag),
    .rx_complete_flag(rx_complete_flag), .receive_holding(receive_holding),
    .frame_error_flag(frame_error_flag), .overflow_flag(overflow_flag),
    .parity_error_flag(parity_error_flag));
  uftr_remote u_rem (.core_clk(core_clk), .sample_tick(sample_tick), .cfg(cfg),
    .txd(txd_line), .sck(sck_out), .rxd(rxd_pin));
  always #12.5 core_clk = ~core_clk;
  // tick every other clock: a bit is 32 clocks; cycle ceiling guards hangs
  always @(posedge core_clk) begin
    sample_tick <= ~sample_tick;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tx_put(input logic [8:0] d);
    repeat (3) @(negedge core_clk);
    for (int n = 0; n < 1000 && tx_buffer_empty_flag !== 1'b1; n++) @(negedge core_clk);
    @(posedge core_clk);
    tx_write <= 1'b1; // only into an empty buffer
    transmit_holding <= d; // ninth bit lands with the rest
    tx_complete_clear <= 1'b1;
    @(posedge core_clk);
    tx_write <= 1'b0;
    tx_complete_clear <= 1'b0;
  endtask
  task automatic wait_tc();
    @(negedge core_clk); // the clear sent with the write has landed by now
    for (int n = 0; n < 2000 && tx_complete_flag !== 1'b1; n++) @(negedge core_clk);
    chk({11'h000, tx_complete_flag}, 12'h001);
    @(posedge core_clk);
  endtask
  task automatic tx(input logic [8:0] d);
    tx_put(d);
    wait_tc();
  endtask
  // flags and data are taken before the pop
  task automatic rd(input logic [11:0] e);
    repeat (2) @(negedge core_clk);
    chk({11'h000, rx_complete_flag}, 12'h001);
    chk({frame_error_flag, overflow_flag, parity_error_flag, receive_holding}, e);
    @(posedge core_clk);
    receive_low_read <= 1'b1;
    @(posedge core_clk);
    receive_low_read <= 1'b0;
    @(posedge core_clk); // pop has settled before the caller looks
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk({8'h00, txd_out, txd_oe, tx_buffer_empty_flag, tx_complete_flag}, 12'h00A);
    @(posedge core_clk);
    cfg.tx_enable <= 1'b1;
    cfg.rx_enable <= 1'b1;
    // every parity mode, shortest and longest characters, both ways
    for (int i = 0; i < 6; i++) begin
      cfg.parity_select <= (i % 3 == 0) ? PAR_NONE : ((i % 3 == 1) ? PAR_EVEN : PAR_ODD);
      cfg.char_size <= (i < 3) ? 4'h5 : 4'h9;
      cfg.two_stop <= i[0];
      w = (9'h1B3 ^ 9'(i)) & ((i < 3) ? 9'h01F : 9'h1FF);
      tx(9'h1B3 ^ 9'(i));
      chk({3'h0, u_rem.got_data}, {3'h0, w});
      if (i % 3 != 0) chk({11'h000, u_rem.got_par}, {11'h000, ^w ^ (i % 3 == 2)});
      chk({11'h000, u_rem.got_stop}, 12'h001);
      u_rem.send(w, i == 4, i != 5);
      rd({i == 5, 1'b0, i == 4, w});
    end
    cfg.receiver_mode_field <= 1'b1;
    cfg.char_size <= 4'h8;
    // identifier 2C gives P0 = 1, P1 = 1 (EC); AC spoils P0
    for (int j = 0; j < 3; j++) begin
      lin_pid_frame <= (j < 2);
      u_rem.send((j > 0) ? 9'h0AC : 9'h0EC, 1'b0, 1'b1);
      rd({2'h0, j == 1, (j > 0) ? 9'h0AC : 9'h0EC});
    end
    lin_pid_frame <= 1'b0;
    cfg.receiver_mode_field <= 1'b0;
    // one frame more than the buffer holds; the last is dropped
    for (int k = 0; k < 33; k++) u_rem.send(9'(k), 1'b0, 1'b1);
    for (int k = 0; k < 32; k++) rd({3'h0, 9'(k)});
    chk({11'h000, rx_complete_flag}, 12'h000);
    u_rem.send(9'h077, 1'b0, 1'b1);
    rd(12'h477);
    // one stored frame and one half received are both lost
    u_rem.send(9'h011, 1'b0, 1'b1);
    fork
      u_rem.send(9'h022, 1'b0, 1'b1);
      begin
        repeat (200) @(posedge core_clk);
        cfg.rx_enable <= 1'b0;
      end
    join
    chk({11'h000, rx_complete_flag}, 12'h000);
    cfg.rx_enable <= 1'b1;
    u_rem.glitch();
    chk({11'h000, rx_complete_flag}, 12'h000);
    u_rem.send(9'h033, 1'b0, 1'b1);
    rd(12'h033);
    // double speed: eight samples per bit both ways
    cfg.double_speed <= 1'b1;
    tx(9'h05C);
    chk({3'h0, u_rem.got_data}, 12'h05C);
    u_rem.send(9'h05C, 1'b0, 1'b1);
    rd(12'h05C);
    cfg.double_speed <= 1'b0;
    cfg.spi_master <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      cfg.bit_order_select <= b[0];
      u_rem.spi_q = 8'h00;
      tx(9'h0C1);
      chk({4'h0, u_rem.spi_q}, b ? 12'h083 : 12'h0C1);
      chk({11'h000, txd_out}, 12'h001);
      rd(12'h0FF); // data in idles high, so eight ones come back
    end
    // disable with a frame shifting and one waiting
    cfg.spi_master <= 1'b0;
    cfg.one_wire <= 1'b1;
    tx_put(9'h05A);
    tx_put(9'h0A5);
    cfg.tx_enable <= 1'b0;
    @(negedge core_clk);
    chk({10'h000, pin_override, txd_oe}, 12'h003);
    wait_tc();
    repeat (2) @(negedge core_clk);
    chk({3'h0, u_rem.got_data}, 12'h0A5);
    chk({10'h000, pin_override, txd_oe}, 12'h000);
    complete_run();
  end
endmodule
`default_nettype wire
